// file: fault_ctrl_pkg.sv
`default_nettype none
package fault_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int TMR_W  = 27;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] FAULT_OFFSET  = 4'h8;

  // Control fields
  localparam int CTRL_VOLT_LSB = 0;
  localparam int CTRL_VOLT_MSB = 1;
  localparam int CTRL_EST_BIT  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Contract voltage codes
  localparam logic [1:0] VOLT_5V  = 2'h0;
  localparam logic [1:0] VOLT_MID = 2'h1;
  localparam logic [1:0] VOLT_TOP = 2'h2;

  // Fault flag positions
  localparam int FLT_FAST_OV   = 0;
  localparam int FLT_SLOW_OV   = 1;
  localparam int FLT_SLOW_UV   = 2;
  localparam int FLT_OCP       = 3;
  localparam int FLT_GD_TMO    = 4;
  localparam int FLT_SUPPLY    = 5;
  localparam int FLT_VBUS_RISE = 6;
  localparam int FLT_STARTUP   = 7;
  localparam int FLT_W         = 8;

  // Synchronised input positions
  localparam int IN_CC1      = 0;
  localparam int IN_CC2      = 1;
  localparam int IN_ACC      = 2;
  localparam int IN_DANGLE   = 3;
  localparam int IN_VBUS_RTH = 4;
  localparam int IN_VBUS_FTH = 5;
  localparam int IN_VBUS_UV  = 6;
  localparam int IN_FAST_OV  = 7;
  localparam int IN_SLOW_OV  = 8;
  localparam int IN_SLOW_UV  = 9;
  localparam int IN_OCP      = 10;
  localparam int IN_GD_N     = 11;
  localparam int IN_SUP_OK   = 12;
  localparam int IN_LOW_OK   = 13;
  localparam int IN_THERMAL  = 14;
  localparam int IN_W        = 15;

  // Times in ms and the clock rate in kHz
  localparam int CLK_KHZ         = 100000;
  localparam int T_CC_DEB_MS     = 150;
  localparam int T_ARM_MS        = 30;
  localparam int T_GD_LOW_MS     = 600;
  localparam int T_SUPPLY_MS     = 600;
  localparam int T_VBUS_RISE_MS  = 190;
  localparam int T_DISCHARGE_MS  = 250;

  localparam logic [TMR_W-1:0] CC_DEB_CYC    = TMR_W'(T_CC_DEB_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] ARM_CYC       = TMR_W'(T_ARM_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] GD_LOW_CYC    = TMR_W'(T_GD_LOW_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] SUPPLY_CYC    = TMR_W'(T_SUPPLY_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] VBUS_RISE_CYC =
    TMR_W'(T_VBUS_RISE_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] DISCHARGE_CYC =
    TMR_W'(T_DISCHARGE_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] STARTUP_CYC   = 27'h0000002;

  typedef enum logic [3:0] {
    ST_STARTUP, ST_BLOCKED, ST_SLEEP, ST_DEBOUNCE, ST_SUPPLY_WAIT,
    ST_POWER_ON, ST_ON, ST_HARD_RESET, ST_DISCHARGE, ST_FAULT_HOLD
  } state_type;
endpackage
`default_nettype wire

// file: source_port_fault_control.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module source_port_fault_control
  import fault_ctrl_pkg::*;
#(
  parameter logic [TMR_W-1:0] CC_DEB_CYCLES    = CC_DEB_CYC,
  parameter logic [TMR_W-1:0] ARM_CYCLES       = ARM_CYC,
  parameter logic [TMR_W-1:0] GD_LOW_CYCLES    = GD_LOW_CYC,
  parameter logic [TMR_W-1:0] SUPPLY_CYCLES    = SUPPLY_CYC,
  parameter logic [TMR_W-1:0] VBUS_RISE_CYCLES = VBUS_RISE_CYC,
  parameter logic [TMR_W-1:0] DISCHARGE_CYCLES = DISCHARGE_CYC
) (
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic [fault_ctrl_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [fault_ctrl_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                                reg_write,
  input  wire logic                                reg_read,
  output logic      [fault_ctrl_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                                cc1_in_window,
  input  wire logic                                cc2_in_window,
  input  wire logic                                cc_accessory,
  input  wire logic                                cc_dangling,
  input  wire logic                                vbus_above_rising,
  input  wire logic                                vbus_above_falling,
  input  wire logic                                vbus_above_uvlo,
  input  wire logic                                fast_ov_trip,
  input  wire logic                                slow_ov_trip,
  input  wire logic                                slow_uv_trip,
  input  wire logic                                overcurrent_trip,
  input  wire logic                                gate_disable_in_n,
  input  wire logic                                supply_above_uvlo,
  input  wire logic                                low_supply_ok,
  input  wire logic                                thermal_shutdown,
  output logic                                     gate_drive_out,
  output logic                                     gate_source_sense,
  output logic                                     hard_reset_req,
  output logic                                     discharge_en,
  output logic      [1:0]                          fast_ov_threshold,
  output logic                                     supply_select_low_o,
  output logic                                     supply_select_low_oe,
  output logic                                     supply_select_high_o,
  output logic                                     supply_select_high_oe,
  output logic                                     attach_indicator_n_o,
  output logic                                     attach_indicator_n_oe,
  output logic                                     digital_supply_out_o,
  output logic                                     digital_supply_out_oe,
  output logic                                     aux_from_low_supply,
  output logic                                     sleep_mode
);
  import fault_ctrl_pkg::*;

  function automatic logic [TMR_W-1:0] sat_inc(
    input logic [TMR_W-1:0] cnt,
    input logic [TMR_W-1:0] lim
  );
    sat_inc = (cnt >= lim) ? cnt : cnt + 1'b1;
  endfunction

  // Input synchroniser; only the second stage is read
  logic [IN_W-1:0] sync1_q;
  logic [IN_W-1:0] sync2_q;
  wire  [IN_W-1:0] raw_in = {thermal_shutdown, low_supply_ok,
                             supply_above_uvlo, gate_disable_in_n,
                             overcurrent_trip, slow_uv_trip, slow_ov_trip,
                             fast_ov_trip, vbus_above_uvlo,
                             vbus_above_falling, vbus_above_rising,
                             cc_dangling, cc_accessory, cc2_in_window,
                             cc1_in_window};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire rst = sys_rst | sync2_q[IN_THERMAL];

  wire cc1_s      = sync2_q[IN_CC1];
  wire cc2_s      = sync2_q[IN_CC2];
  wire acc_s      = sync2_q[IN_ACC];
  wire vbus_rth_s = sync2_q[IN_VBUS_RTH];
  wire vbus_fth_s = sync2_q[IN_VBUS_FTH];
  wire vbus_uv_s  = sync2_q[IN_VBUS_UV];
  wire gd_s       = sync2_q[IN_GD_N];
  wire plug_now   = 1'b0;
  wire [3:0] plug_s = {sync2_q[IN_DANGLE], acc_s, cc2_s, cc1_s};
  wire sink_s     = cc1_s ^ cc2_s;

  state_type state_q;
  state_type state_d;
  logic [TMR_W-1:0] timer_q;
  logic [TMR_W-1:0] absent_q;
  logic [TMR_W-1:0] gdlow_q;
  logic [TMR_W-1:0] arm_q;
  logic [TMR_W-1:0] ocp_cnt_q;
  logic [TMR_W-1:0] trans_q;
  logic [3:0]       plug_q;
  logic [2:0]       ctrl_q;
  logic [FLT_W-1:0] fault_q;
  logic [FLT_W-1:0] fault_set;
  logic             keep_q;
  logic             keep_d;
  logic             gate_q;
  logic             rth_seen_q;
  logic             trans_up_q;
  logic             trans_dn_q;
  logic             hard_reset_q;
  logic             discharge_q;
  logic [DATA_W-1:0] rdata_q;

  wire [1:0] volt_q = ctrl_q[CTRL_VOLT_MSB:CTRL_VOLT_LSB];
  wire [1:0] volt_w = reg_wdata[CTRL_VOLT_MSB:CTRL_VOLT_LSB];
  wire wr_ctrl  = reg_write && (reg_addr == CTRL_OFFSET);
  wire wr_fault = reg_write && (reg_addr == FAULT_OFFSET);

  wire attached = (state_q == ST_SUPPLY_WAIT) || (state_q == ST_POWER_ON) ||
                  (state_q == ST_ON) || (state_q == ST_HARD_RESET) ||
                  (state_q == ST_DISCHARGE) || (state_q == ST_FAULT_HOLD);
  wire powered  = (state_q == ST_POWER_ON) || (state_q == ST_ON);
  wire timer_done_deb  = timer_q >= CC_DEB_CYCLES;
  wire detach_done     = absent_q >= CC_DEB_CYCLES;
  wire gd_timeout      = gdlow_q >= GD_LOW_CYCLES;
  wire slow_armed      = arm_q >= ARM_CYCLES;
  wire ocp_armed       = ocp_cnt_q >= ARM_CYCLES;
  wire fast_ov_hit     = sync2_q[IN_FAST_OV];
  wire ocp_hit = sync2_q[IN_OCP] || (ocp_armed && !vbus_fth_s);
  wire slow_ov_hit = slow_armed && !trans_up_q && sync2_q[IN_SLOW_OV];
  wire slow_uv_hit = slow_armed && !trans_dn_q && sync2_q[IN_SLOW_UV];
  wire rise_tmo    = (state_q == ST_POWER_ON) &&
                     (timer_q >= VBUS_RISE_CYCLES) && !vbus_uv_s;

  always_comb begin
    state_d   = state_q;
    keep_d    = 1'b0;
    fault_set = '0;
    unique case (state_q)
      ST_STARTUP: begin
        if (timer_q >= STARTUP_CYC) begin
          state_d = vbus_uv_s ? ST_BLOCKED : ST_DEBOUNCE;
          fault_set[FLT_STARTUP] = vbus_uv_s;
        end
      end
      ST_BLOCKED: begin
        if (!vbus_uv_s) state_d = ST_DEBOUNCE;
      end
      ST_SLEEP: begin
        if (plug_s != plug_q) state_d = ST_DEBOUNCE;
      end
      ST_DEBOUNCE: begin
        if (sink_s && !vbus_fth_s) begin
          if (timer_done_deb) state_d = ST_SUPPLY_WAIT;
        end else if (!sink_s && !acc_s) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SUPPLY_WAIT: begin
        if (sync2_q[IN_SUP_OK] && gd_s) begin
          state_d = ST_POWER_ON;
        end else if (!sync2_q[IN_SUP_OK] && timer_q >= SUPPLY_CYCLES) begin
          state_d = ST_FAULT_HOLD;
          fault_set[FLT_SUPPLY] = 1'b1;
        end
      end
      ST_POWER_ON, ST_ON: begin
        if (fast_ov_hit) begin
          state_d = ST_HARD_RESET;
          fault_set[FLT_FAST_OV] = 1'b1;
        end else if (ocp_hit) begin
          state_d = ST_HARD_RESET;
          fault_set[FLT_OCP] = 1'b1;
        end else if (slow_ov_hit || slow_uv_hit) begin
          state_d = ST_HARD_RESET;
          keep_d  = 1'b1;
          fault_set[FLT_SLOW_OV] = slow_ov_hit;
          fault_set[FLT_SLOW_UV] = slow_uv_hit;
        end else if (rise_tmo) begin
          state_d = ST_DISCHARGE;
          fault_set[FLT_VBUS_RISE] = 1'b1;
        end else if (state_q == ST_POWER_ON && vbus_uv_s) begin
          state_d = ST_ON;
        end
      end
      ST_HARD_RESET: begin
        state_d = ST_DISCHARGE;
      end
      ST_DISCHARGE: begin
        if (timer_q >= DISCHARGE_CYCLES) state_d = ST_DEBOUNCE;
      end
      ST_FAULT_HOLD: begin
        state_d = ST_FAULT_HOLD;
      end
    endcase
    if (attached && gd_timeout && state_q != ST_HARD_RESET &&
        state_q != ST_DISCHARGE) begin
      state_d = ST_HARD_RESET;
      keep_d  = 1'b0;
      fault_set[FLT_GD_TMO] = 1'b1;
    end
    if (attached && detach_done && state_q != ST_DISCHARGE) begin
      state_d = ST_DISCHARGE;
    end
  end

  wire gate_d = gd_s && !plug_now &&
                ((state_d == ST_POWER_ON) || (state_d == ST_ON) ||
                 (state_d == ST_HARD_RESET && keep_d));

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_STARTUP;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? '0 : sat_inc(timer_q, '1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      absent_q  <= '0;
      gdlow_q   <= '0;
      arm_q     <= '0;
      ocp_cnt_q <= '0;
    end else begin
      absent_q  <= (attached && !sink_s) ?
                   sat_inc(absent_q, CC_DEB_CYCLES) : '0;
      gdlow_q   <= (attached && !gd_s) ? sat_inc(gdlow_q, GD_LOW_CYCLES) : '0;
      arm_q     <= gate_q ? sat_inc(arm_q, ARM_CYCLES) : '0;
      ocp_cnt_q <= (gate_q && rth_seen_q) ?
                   sat_inc(ocp_cnt_q, ARM_CYCLES) : '0;
    end
  end

  // Transition window masks the slow OV check while the supply moves up and the slow UV check while it moves down
  always_ff @(posedge clk) begin
    if (rst) begin
      trans_up_q <= 1'b0;
      trans_dn_q <= 1'b0;
      trans_q    <= '0;
    end else if (wr_ctrl && volt_w != volt_q) begin
      trans_up_q <= volt_w > volt_q;
      trans_dn_q <= volt_w < volt_q;
      trans_q    <= '0;
    end else if (trans_q >= ARM_CYCLES) begin
      trans_up_q <= 1'b0;
      trans_dn_q <= 1'b0;
    end else begin
      trans_q    <= sat_inc(trans_q, ARM_CYCLES);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_q       <= 1'b0;
      keep_q       <= 1'b0;
      rth_seen_q   <= 1'b0;
      hard_reset_q <= 1'b0;
      discharge_q  <= 1'b0;
      plug_q       <= '0;
    end else begin
      gate_q       <= gate_d;
      keep_q       <= keep_d;
      rth_seen_q   <= gate_q && (rth_seen_q || vbus_rth_s);
      hard_reset_q <= (state_d == ST_HARD_RESET) &&
                      (state_q != ST_HARD_RESET);
      discharge_q  <= state_d == ST_DISCHARGE;
      plug_q       <= (state_q == ST_SLEEP) ? plug_q : plug_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[CTRL_EST_BIT:CTRL_VOLT_LSB];
    end else if (!attached) begin
      ctrl_q <= CTRL_RESET;
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  wire [FLT_W-1:0] fault_clr = wr_fault ? reg_wdata[FLT_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_q <= '0;
    end else begin
      fault_q <= (fault_q & ~fault_clr) | fault_set;
    end
  end

  wire [DATA_W-1:0] status_word = {{(DATA_W-9){1'b0}}, sleep_mode,
                                   ocp_armed, slow_armed, attached, gate_q,
                                   state_q};
  wire [DATA_W-1:0] read_mux =
    (reg_addr == CTRL_OFFSET)   ? {{(DATA_W-3){1'b0}}, ctrl_q} :
    (reg_addr == STATUS_OFFSET) ? status_word :
    (reg_addr == FAULT_OFFSET)  ? {{(DATA_W-FLT_W){1'b0}}, fault_q} :
                                  '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_read ? read_mux : '0;
    end
  end

  assign reg_rdata             = rdata_q;
  assign gate_drive_out        = gate_q;
  assign gate_source_sense     = gate_q;
  assign hard_reset_req        = hard_reset_q;
  assign discharge_en          = discharge_q;
  assign fast_ov_threshold     = volt_q;
  assign supply_select_low_o   = 1'b0;
  assign supply_select_low_oe  = volt_q != VOLT_5V;
  assign supply_select_high_o  = 1'b0;
  assign supply_select_high_oe = volt_q == VOLT_TOP;
  assign attach_indicator_n_o  = 1'b0;
  assign attach_indicator_n_oe = attached;
  assign digital_supply_out_o  = 1'b1;
  assign digital_supply_out_oe = attached || acc_s;
  assign aux_from_low_supply   = ctrl_q[CTRL_EST_BIT] && sync2_q[IN_LOW_OK];
  assign sleep_mode            = state_q == ST_SLEEP;
endmodule // source_port_fault_control
`default_nettype wire

// file: source_port_fault_control_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module source_port_fault_control_asserts
  import fault_ctrl_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       fast_ov_trip,
  input wire logic       gate_disable_in_n,
  input wire logic       thermal_shutdown,
  input wire logic       gate_drive_out,
  input wire logic       gate_source_sense,
  input wire logic       hard_reset_req,
  input wire logic       discharge_en,
  input wire logic [1:0] fast_ov_threshold,
  input wire logic       supply_select_low_oe,
  input wire logic       supply_select_high_oe,
  input wire logic       attach_indicator_n_oe,
  input wire logic       digital_supply_out_oe,
  input wire logic       sleep_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_select_code: assert property ($stable(fast_ov_threshold)[*2] |->
    supply_select_low_oe == (fast_ov_threshold != VOLT_5V) &&
    supply_select_high_oe == (fast_ov_threshold == VOLT_TOP))
    else $error("supply select does not match contract code");
  a_fast_ov_off: assert property (gate_drive_out && $rose(fast_ov_trip)
    ##1 fast_ov_trip[*2] |-> ##[0:2] hard_reset_req ##1 discharge_en)
    else $error("fast overvoltage did not lead to hard reset");
  a_gd_force_off: assert property (!gate_disable_in_n[*4] |->
    !gate_drive_out && !gate_source_sense)
    else $error("gate still on with disable input low");
  a_hr_single: assert property (hard_reset_req |=> !hard_reset_req)
    else $error("hard reset request longer than one cycle");
  a_hr_before_off: assert property (hard_reset_req && gate_drive_out
    |=> !gate_drive_out && discharge_en)
    else $error("gate not dropped after slow fault hard reset");
  a_discharge_off: assert property (discharge_en |-> !gate_drive_out)
    else $error("gate on during discharge");
  a_thermal_reset: assert property (thermal_shutdown[*4] |->
    ##[0:1] !gate_drive_out && !attach_indicator_n_oe)
    else $error("thermal shutdown did not reset outputs");
  a_attach_supply: assert property (attach_indicator_n_oe |->
    digital_supply_out_oe)
    else $error("digital supply released while attached");
  a_sleep_idle: assert property (sleep_mode |->
    !attach_indicator_n_oe && !gate_drive_out)
    else $error("sleeping with sink attached");
  a_reset_5v: assert property ($fell(sys_rst) |->
    fast_ov_threshold == VOLT_5V)
    else $error("threshold not at 5 V code after reset");
endmodule // source_port_fault_control_asserts
`default_nettype wire

// file: sink_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module sink_supply_model #(
  parameter int RISE_DLY = 4,
  parameter int SUP_DLY  = 6
) (
  input  wire logic clk,
  input  wire logic sink_present,
  input  wire logic vbus_force,
  input  wire logic slow_supply,
  input  wire logic gate_drive_out,
  input  wire logic attach_indicator_n_oe,
  output logic      cc1_in_window,
  output logic      vbus_above_rising,
  output logic      vbus_above_falling,
  output logic      vbus_above_uvlo,
  output logic      supply_above_uvlo
);
  int  rise_cnt = 0;
  int  sup_cnt  = 0;
  wire logic vbus_up;
  assign cc1_in_window = sink_present;
  // Supply and VBUS come up in bounded time, the supply only while slow_supply is low
  always @(posedge clk) begin
    rise_cnt <= !gate_drive_out ? 0 : (rise_cnt < RISE_DLY) ? rise_cnt + 1
                                                       : rise_cnt;
    sup_cnt  <= !attach_indicator_n_oe ? 0 : (sup_cnt < SUP_DLY) ? sup_cnt + 1
                                                        : sup_cnt;
  end
  // VBUS collapses one clock after gate off unless vbus_force holds it, the harshest load
  assign vbus_up = vbus_force || (rise_cnt == RISE_DLY);
  assign vbus_above_rising  = vbus_up;
  assign vbus_above_falling = vbus_up;
  assign vbus_above_uvlo    = vbus_up;
  // Slow mode breaks the supply timing on purpose
  assign supply_above_uvlo = !slow_supply && (sup_cnt == SUP_DLY);
endmodule // sink_supply_model
`default_nettype wire

// file: source_port_fault_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
`define WAITF(c,n) begin for (wi = 0; wi < (n) && !(c); wi++) \
  @(posedge clk); if (!(c)) begin err_count++; end_sim; end end
module source_port_fault_control_tb;
  import fault_ctrl_pkg::*;
  logic clk, sys_rst, reg_write, reg_read, cc2_in_window, cc_accessory;
  logic cc_dangling, fast_ov_trip, slow_ov_trip, slow_uv_trip;
  logic overcurrent_trip, gate_disable_in_n, low_supply_ok;
  logic thermal_shutdown, sink_present, vbus_force, slow_supply;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
  logic cc1_in_window, vbus_above_rising, vbus_above_falling;
  logic vbus_above_uvlo, supply_above_uvlo, gate_drive_out;
  logic gate_source_sense, hard_reset_req, discharge_en, sleep_mode;
  logic supply_select_low_o, supply_select_low_oe, supply_select_high_o;
  logic supply_select_high_oe, attach_indicator_n_o, attach_indicator_n_oe;
  logic digital_supply_out_o, digital_supply_out_oe, aux_from_low_supply;
  logic [1:0] fast_ov_threshold;
  int err_count = 0;
  int checks = 0;
  int wi;

  // Short counts keep the run small
  source_port_fault_control #(.CC_DEB_CYCLES(27'd20), .ARM_CYCLES(27'd10),
    .GD_LOW_CYCLES(27'd200), .SUPPLY_CYCLES(27'd200),
    .VBUS_RISE_CYCLES(27'd50), .DISCHARGE_CYCLES(27'd30)) dut (.*);
  sink_supply_model #(.RISE_DLY(4), .SUP_DLY(6)) far (.*);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task end_sim;
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rdr(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    rd = reg_rdata;
  endtask
  task t_idle;
    `CHK(fast_ov_threshold, VOLT_5V)
    `CHK({supply_select_low_oe, supply_select_high_oe}, 2'h0)
    `CHK(attach_indicator_n_oe, 1'b0)
    rdr(4'hc);
    `CHK(rd, 32'h0)
    cc_dangling <= 1'b1;
    `WAITF(sleep_mode, 30)
    cc_dangling <= 1'b0;
    cc_accessory <= 1'b1;
    `WAITF(digital_supply_out_oe, 10)
    cc_accessory <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task t_attach;
    sink_present <= 1'b1;
    `WAITF(!sleep_mode, 5)
    `WAITF(attach_indicator_n_oe, 60)
    `CHK(wi >= 20, 1'b1)
    `WAITF(gate_drive_out, 40)
    rdr(STATUS_OFFSET);
    `CHK(rd[7], 1'b0)
    repeat (15) @(posedge clk);
    rdr(STATUS_OFFSET);
    `CHK(rd[7], 1'b1)
  endtask
  task t_contract;
    low_supply_ok <= 1'b1;
    for (int i = 2; i >= 0; i--) begin
      wr(CTRL_OFFSET, {29'h0, 1'b1, 2'(i)});
      repeat (3) @(posedge clk);
      `CHK(fast_ov_threshold, 2'(i))
      `CHK(supply_select_high_oe, i == 2)
      `CHK(supply_select_low_oe, i != 0)
      `CHK(aux_from_low_supply, 1'b1)
    end
    low_supply_ok <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(aux_from_low_supply, 1'b0)
  endtask
  task t_fast_ov;
    fast_ov_trip <= 1'b1;
    `WAITF(hard_reset_req, 8)
    `CHK(gate_drive_out, 1'b0)
    fast_ov_trip <= 1'b0;
    rdr(FAULT_OFFSET);
    `CHK(rd[FLT_FAST_OV], 1'b1)
    wr(FAULT_OFFSET, 32'h1);
    rdr(FAULT_OFFSET);
    `CHK(rd[FLT_FAST_OV], 1'b0)
    `WAITF(!discharge_en, 60)
    `WAITF(gate_drive_out, 150)
  endtask
  task t_trips;
    overcurrent_trip <= 1'b1;
    `WAITF(hard_reset_req, 8)
    `CHK({gate_drive_out, gate_source_sense}, 2'h0)
    overcurrent_trip <= 1'b0;
    `WAITF(gate_drive_out, 150)
    repeat (15) @(posedge clk);
    slow_ov_trip <= 1'b1;
    `WAITF(hard_reset_req, 8)
    `CHK(gate_drive_out, 1'b1)
    @(posedge clk);
    `CHK(gate_drive_out, 1'b0)
    slow_ov_trip <= 1'b0;
    rdr(FAULT_OFFSET);
    `CHK(rd[FLT_SLOW_OV], 1'b1)
    `WAITF(gate_drive_out, 150)
  endtask
  task t_gd;
    gate_disable_in_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(gate_drive_out, 1'b0)
    `WAITF(hard_reset_req, 260)
    rdr(FAULT_OFFSET);
    `CHK(rd[FLT_GD_TMO], 1'b1)
    gate_disable_in_n <= 1'b1;
  endtask
  task t_supply;
    sink_present <= 1'b0;
    `WAITF(sleep_mode, 400)
    slow_supply <= 1'b1;
    sink_present <= 1'b1;
    `WAITF(attach_indicator_n_oe, 60)
    repeat (215) @(posedge clk);
    `CHK(gate_drive_out, 1'b0)
    rdr(FAULT_OFFSET);
    `CHK(rd[FLT_SUPPLY], 1'b1)
    thermal_shutdown <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(attach_indicator_n_oe, 1'b0)
    thermal_shutdown <= 1'b0;
    sink_present <= 1'b0;
    slow_supply <= 1'b0;
  endtask
  task t_start;
    vbus_force <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK(gate_drive_out, 1'b0)
    rdr(FAULT_OFFSET);
    `CHK(rd[FLT_STARTUP], 1'b1)
    vbus_force <= 1'b0;
  endtask

  initial begin
    {reg_write, reg_read, cc2_in_window, cc_accessory, cc_dangling} = '0;
    {fast_ov_trip, slow_ov_trip, slow_uv_trip, overcurrent_trip} = '0;
    {low_supply_ok, thermal_shutdown, sink_present, vbus_force} = '0;
    {slow_supply, reg_addr, reg_wdata} = '0;
    gate_disable_in_n = 1'b1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_idle;
    t_attach;
    t_contract;
    t_fast_ov;
    t_trips;
    t_gd;
    t_supply;
    t_start;
    end_sim;
  end
endmodule // source_port_fault_control_tb
bind source_port_fault_control source_port_fault_control_asserts chk (.*);
`default_nettype wire
